// file: duhbp_device.sv
`timescale 1ns/1ps
`include "duhbp_consts.svh"
module duhbp_device #(
    parameter int NUM_REGS = `DUHBP_NUM_REGS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Host bus pins
    duhbp_if.device bus,
    // Channel side
    input wire logic chan_a_int_req,
    input wire logic chan_b_int_req,
    output logic [7:0] chan_a_mcr,
    output logic [7:0] chan_b_mcr,
    output logic write_pulse,
    output logic write_chan_b,
    output logic [2:0] write_addr,
    output logic [7:0] write_data
);
    import duhbp_pkg::*;

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [1:0] sty_s;
        logic [1:0] rd_s;
        logic [1:0] wr_s;
        logic [1:0] csa_s;
        logic [1:0] csb_s;
        logic [2:0] addr_s0;
        logic [2:0] addr_s1;
        logic [7:0] dat_s0;
        logic [7:0] dat_s1;
        logic rd_act;
        logic wr_act;
        logic act_chan_b;
        logic [2:0] act_addr;
        logic [7:0] rd_data;
        logic wr_pulse;
        logic wr_chan_b;
        logic [2:0] wr_addr;
        logic [7:0] wr_data;
    } duhbp_dev_state_t;

    duhbp_dev_state_t st;
    duhbp_dev_state_t next_st;
    logic [7:0] regs_a [NUM_REGS];
    logic [7:0] regs_b [NUM_REGS];

    // Elaboration check: the decode reaches exactly this many registers
    if (NUM_REGS != (1 << `DUHBP_ADDR_W)) begin
        $error("NUM_REGS must equal 2**address width");
    end

    // Synchronised pin levels (second stage only)
    logic style_strobe;
    logic rd_n;
    logic wr_n;
    logic csa_n;
    logic csb_n;
    assign style_strobe = st.sty_s[1];
    assign rd_n = st.rd_s[1];
    assign wr_n = st.wr_s[1];
    assign csa_n = st.csa_s[1];
    assign csb_n = st.csb_s[1];

    // ************************************************
    // Decode of a request from the synced pins
    // ************************************************
    logic sel_any;
    logic sel_b;
    logic want_rd;
    logic want_wr;
    always_comb begin
        if (style_strobe) begin
            sel_any = !csa_n || !csb_n;
            sel_b = csa_n && !csb_n;
            want_rd = sel_any && !rd_n;
            want_wr = sel_any && !wr_n;
        end else begin
            sel_any = !csa_n;
            sel_b = csb_n;
            want_rd = sel_any && wr_n;
            want_wr = sel_any && !wr_n;
        end
    end

    // Register read of one channel; one decode shared by both arrays
    function automatic logic [7:0] pick(input logic b, input logic [2:0] a);
        pick = b ? regs_b[a] : regs_a[a];
    endfunction

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.sty_s = {st.sty_s[0], bus.bus_style_sel};
        next_st.rd_s = {st.rd_s[0], bus.read_strobe_n};
        next_st.wr_s = {st.wr_s[0], bus.write_strobe_n};
        next_st.csa_s = {st.csa_s[0], bus.chan_a_select_n};
        next_st.csb_s = {st.csb_s[0], bus.chan_b_select_n};
        next_st.addr_s0 = bus.addr;
        next_st.addr_s1 = st.addr_s0;
        next_st.dat_s0 = bus.data_bus;
        next_st.dat_s1 = st.dat_s0;
        next_st.wr_pulse = 1'b0;
        // Start of read: fetch once on the leading edge
        if (want_rd && !st.rd_act) begin
            next_st.rd_act = 1'b1;
            next_st.act_chan_b = sel_b;
            next_st.act_addr = st.addr_s1;
            next_st.rd_data = pick(sel_b, st.addr_s1);
        end else if (!want_rd) begin
            next_st.rd_act = 1'b0;
        end
        // Write: latch target on start, store on trailing edge
        if (want_wr && !st.wr_act) begin
            next_st.wr_act = 1'b1;
            next_st.act_chan_b = sel_b;
            next_st.act_addr = st.addr_s1;
        end else if (want_wr) begin
            next_st.wr_data = st.dat_s1; // Track bus until the trailing edge
        end else if (st.wr_act) begin
            next_st.wr_act = 1'b0;
            next_st.wr_pulse = 1'b1;
            next_st.wr_chan_b = st.act_chan_b;
            next_st.wr_addr = st.act_addr;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.sty_s <= 2'h3;
            st.rd_s <= 2'h3;
            st.wr_s <= 2'h3;
            st.csa_s <= 2'h3;
            st.csb_s <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    // Register arrays; deselect cancels nothing once stored
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_a[i] <= `DUHBP_REG_RST;
                regs_b[i] <= `DUHBP_REG_RST;
            end
        end else if (st.wr_pulse) begin
            if (st.wr_chan_b) begin
                regs_b[st.wr_addr] <= st.wr_data;
            end else begin
                regs_a[st.wr_addr] <= st.wr_data;
            end
        end
    end

    // ************************************************
    // Pin drive
    // ************************************************
    logic irq_en_a;
    logic irq_en_b;
    assign irq_en_a = regs_a[`DUHBP_MCR_ADDR][`DUHBP_MCR_IRQ_EN_BIT];
    assign irq_en_b = regs_b[`DUHBP_MCR_ADDR][`DUHBP_MCR_IRQ_EN_BIT];
    // Bus driven only while a selected read lasts
    assign bus.data_dev_out = st.rd_data;
    assign bus.data_dev_oe = st.rd_act && want_rd;
    always_comb begin
        if (style_strobe) begin
            bus.chan_a_irq_out = chan_a_int_req;
            bus.chan_a_irq_oe = irq_en_a;
            bus.chan_b_irq_out = chan_b_int_req;
            bus.chan_b_irq_oe = irq_en_b;
            bus.chan_a_aux_out_n = !irq_en_a;
        end else begin
            // Open drain: only ever pulls low
            bus.chan_a_irq_out = 1'b0;
            bus.chan_a_irq_oe = chan_a_int_req || chan_b_int_req;
            bus.chan_b_irq_out = 1'b0;
            bus.chan_b_irq_oe = 1'b0;
            bus.chan_a_aux_out_n = !irq_en_a;
        end
    end
    assign chan_a_mcr = regs_a[`DUHBP_MCR_ADDR];
    assign chan_b_mcr = regs_b[`DUHBP_MCR_ADDR];
    assign write_pulse = st.wr_pulse;
    assign write_chan_b = st.wr_chan_b;
    assign write_addr = st.wr_addr;
    assign write_data = st.wr_data;
endmodule

// file: duhbp_consts.svh
`ifndef DUHBP_CONSTS_SVH
`define DUHBP_CONSTS_SVH
// ************************************************
// Widths and field positions
// ************************************************
`define DUHBP_ADDR_W 3
`define DUHBP_DATA_W 8
`define DUHBP_MCR_IRQ_EN_BIT 3
`define DUHBP_NUM_REGS 8
`define DUHBP_MCR_ADDR 3'h4
// ************************************************
// Reset values
// ************************************************
`define DUHBP_REG_RST 8'h00
`define DUHBP_DATA_RST 8'h00
// ************************************************
// Host timing counts (cycles of clk_sys)
// ************************************************
`define DUHBP_SETUP_CYC 2
`define DUHBP_STROBE_CYC 4
`define DUHBP_HOLD_CYC 2
`endif

// file: duhbp_pkg.sv
package duhbp_pkg;
    // Bus style picked by the strap pin
    typedef enum logic {DUHBP_STYLE_DIR, DUHBP_STYLE_STROBE} duhbp_style_t;
    // Host command kinds
    typedef enum logic {DUHBP_CMD_READ, DUHBP_CMD_WRITE} duhbp_cmd_t;
endpackage

// file: duhbp_if.sv
`timescale 1ns/1ps
// ************************************************
// Parallel host bus between processor and dual UART port
// ************************************************
interface duhbp_if;
    // Strap and address
    logic bus_style_sel;
    logic [2:0] addr;
    // Data bus, resolved from both enables
    logic [7:0] data_host_out;
    logic data_host_oe;
    logic [7:0] data_dev_out;
    logic data_dev_oe;
    logic [7:0] data_bus;
    // Strobes and selects
    logic read_strobe_n;
    logic write_strobe_n;
    logic chan_a_select_n;
    logic chan_b_select_n;
    // Interrupt pins, three signals for channel A, two for channel B
    logic chan_a_irq_out;
    logic chan_a_irq_oe;
    logic chan_b_irq_out;
    logic chan_b_irq_oe;
    logic chan_a_aux_out_n;

    // Wire level; a floating bus reads as all ones (pull-ups)
    always_comb begin
        if (data_dev_oe) begin
            data_bus = data_dev_out;
        end else if (data_host_oe) begin
            data_bus = data_host_out;
        end else begin
            data_bus = 8'hFF;
        end
    end

    modport device (
        input bus_style_sel, addr, data_host_out, data_host_oe, data_bus,
        input read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
        output data_dev_out, data_dev_oe,
        output chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out, chan_b_irq_oe,
        output chan_a_aux_out_n
    );
    modport host (
        output bus_style_sel, addr, data_host_out, data_host_oe,
        output read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
        input data_bus, data_dev_out, data_dev_oe,
        input chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out, chan_b_irq_oe,
        input chan_a_aux_out_n
    );
endinterface

// file: duhbp_host.sv
`timescale 1ns/1ps
`include "duhbp_consts.svh"
module duhbp_host #(
    parameter int SETUP_CYC = `DUHBP_SETUP_CYC,
    parameter int STROBE_CYC = `DUHBP_STROBE_CYC,
    parameter int HOLD_CYC = `DUHBP_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Host bus pins
    duhbp_if.host bus,
    // User command
    input wire logic style_strobe,
    input wire logic req_valid,
    output logic req_ready,
    input wire duhbp_pkg::duhbp_cmd_t req_cmd,
    input wire logic req_chan_b,
    input wire logic [2:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    // Interrupt seen on the pins
    output logic irq_seen
);
    import duhbp_pkg::*;

    typedef enum {H_IDLE, H_SETUP, H_STROBE, H_HOLD} duhbp_hstate_t;
    typedef struct packed {
        duhbp_hstate_t fsm;
        logic [7:0] cnt;
        logic is_wr;
        logic chan_b;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic strobe;
        logic sel;
        logic rsp;
        logic [7:0] rdata;
        logic [1:0] irq_s;
    } duhbp_host_state_t;

    duhbp_host_state_t st;
    duhbp_host_state_t next_st;

    // Strobe needs four cycles so the port's synchroniser sees it and fetches
    if (SETUP_CYC < 1 || STROBE_CYC < 4 || HOLD_CYC < 1 ||
        SETUP_CYC > 255 || STROBE_CYC > 255 || HOLD_CYC > 255) begin
        $error("Host timing counts out of range");
    end

    // ************************************************
    // Transaction sequencer
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.rsp = 1'b0;
        next_st.irq_s = {st.irq_s[0], (bus.chan_a_irq_oe &&
            (style_strobe ? bus.chan_a_irq_out : !bus.chan_a_irq_out)) ||
            (style_strobe && bus.chan_b_irq_oe && bus.chan_b_irq_out)};
        case (st.fsm)
            H_IDLE: begin
                if (req_valid) begin
                    next_st.fsm = H_SETUP;
                    next_st.cnt = 8'(SETUP_CYC);
                    next_st.is_wr = (req_cmd == DUHBP_CMD_WRITE);
                    next_st.chan_b = req_chan_b;
                    next_st.addr = req_addr;
                    next_st.wdata = req_wdata;
                    next_st.sel = 1'b1;
                end
            end
            H_SETUP: begin
                next_st.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h01) begin
                    next_st.fsm = H_STROBE;
                    next_st.cnt = 8'(STROBE_CYC);
                    next_st.strobe = 1'b1;
                end
            end
            H_STROBE: begin
                next_st.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h01) begin
                    next_st.fsm = H_HOLD;
                    next_st.cnt = 8'(HOLD_CYC);
                    next_st.strobe = 1'b0;
                    if (!st.is_wr) begin
                        // Strobe rises at this edge; take the byte now
                        next_st.rdata = bus.data_bus;
                        next_st.rsp = 1'b1;
                    end
                end
            end
            H_HOLD: begin
                next_st.cnt = st.cnt - 8'h01;
                if (st.cnt == 8'h01) begin
                    next_st.fsm = H_IDLE;
                    next_st.sel = 1'b0;
                    next_st.rsp = st.is_wr;
                end
            end
            default: next_st.fsm = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************
    // Pin drive
    // ************************************************
    always_comb begin
        bus.bus_style_sel = style_strobe;
        bus.addr = st.addr;
        bus.data_host_out = st.wdata;
        bus.data_host_oe = st.sel && st.is_wr;
        if (style_strobe) begin
            bus.read_strobe_n = !(st.strobe && !st.is_wr);
            bus.write_strobe_n = !(st.strobe && st.is_wr);
            bus.chan_a_select_n = !(st.sel && !st.chan_b);
            bus.chan_b_select_n = !(st.sel && st.chan_b);
        end else begin
            // Select A is itself the strobe window; direction held throughout
            bus.read_strobe_n = 1'b1;
            bus.write_strobe_n = !st.is_wr || !st.sel;
            bus.chan_a_select_n = !st.strobe;
            bus.chan_b_select_n = st.chan_b;
        end
    end
    assign req_ready = (st.fsm == H_IDLE);
    assign rsp_valid = st.rsp;
    assign rsp_rdata = st.rdata;
    assign irq_seen = st.irq_s[1];
endmodule

// file: duhbp_bus_properties.sv
`timescale 1ns/1ps
// ********
// Host bus port properties
// ********
module duhbp_bus_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Bus pins
    input wire logic bus_style_sel,
    input wire logic data_host_oe,
    input wire logic [7:0] data_dev_out,
    input wire logic data_dev_oe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    // Interrupt pins
    input wire logic chan_a_irq_out,
    input wire logic chan_a_irq_oe,
    input wire logic chan_b_irq_oe,
    input wire logic chan_a_aux_out_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // Read starts; the window allows for the two-stage synchroniser
    sequence s_strobe_rd;
        bus_style_sel && $fell(read_strobe_n) && !(chan_a_select_n && chan_b_select_n);
    endsequence
    sequence s_dir_rd;
        !bus_style_sel && $fell(chan_a_select_n) && write_strobe_n;
    endsequence
    // Four quiet cycles, long enough for the synced read to drop
    sequence s_strobe_idle;
        (bus_style_sel && (read_strobe_n || (chan_a_select_n && chan_b_select_n)))[*4];
    endsequence
    sequence s_dir_idle;
        (!bus_style_sel && (chan_a_select_n || !write_strobe_n))[*4];
    endsequence
    chk_strobe_read_drive: assert property (s_strobe_rd |-> ##[2:3] data_dev_oe)
        else $error("strobe read not driven");
    chk_dir_read_drive: assert property (s_dir_rd |-> ##[2:3] data_dev_oe)
        else $error("direction read not driven");
    chk_strobe_idle_float: assert property (s_strobe_idle |-> !data_dev_oe)
        else $error("bus driven without enabled read");
    chk_dir_idle_float: assert property (s_dir_idle |-> !data_dev_oe)
        else $error("direction style bus driven without read");
    chk_single_driver: assert property (!(data_dev_oe && data_host_oe))
        else $error("both ends drive the data bus");
    chk_read_data_hold: assert property (data_dev_oe && $past(data_dev_oe) |-> $stable(data_dev_out))
        else $error("read data changed while driven");
    chk_aux_follows_irq: assert property (bus_style_sel |-> chan_a_aux_out_n == !chan_a_irq_oe)
        else $error("aux output does not mirror irq enable");
    chk_dir_irq_drain: assert property (!bus_style_sel && chan_a_irq_oe |-> !chan_a_irq_out)
        else $error("shared irq driven high");
    chk_irq_b_unused: assert property (!bus_style_sel |-> !chan_b_irq_oe)
        else $error("irq b driven in direction style");
endmodule

// file: duhbp_tb.sv
`timescale 1ns/1ps
// ********
// Bench driving both ends of the host bus
// ********
module tb;
    import duhbp_pkg::*;
    logic clk_sys, nrst, style_strobe, req_valid, req_chan_b, chan_a_int_req, chan_b_int_req;
    duhbp_cmd_t req_cmd;
    logic [2:0] req_addr, write_addr;
    logic [7:0] req_wdata, rsp_rdata, chan_a_mcr, chan_b_mcr, write_data, rd, wr_data_seen;
    logic req_ready, rsp_valid, irq_seen, write_pulse, write_chan_b;
    logic [3:0] wr_where;
    int failures, n_checks;
    duhbp_if bus_if();
    duhbp_device duhbp_device_inst (.clk_sys(clk_sys), .nrst(nrst), .bus(bus_if),
        .chan_a_int_req(chan_a_int_req), .chan_b_int_req(chan_b_int_req),
        .chan_a_mcr(chan_a_mcr), .chan_b_mcr(chan_b_mcr), .write_pulse(write_pulse),
        .write_chan_b(write_chan_b), .write_addr(write_addr), .write_data(write_data));
    duhbp_host duhbp_host_inst (.clk_sys(clk_sys), .nrst(nrst), .bus(bus_if),
        .style_strobe(style_strobe), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_chan_b(req_chan_b), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .irq_seen(irq_seen));
    duhbp_bus_properties duhbp_bus_properties_inst (.clk_sys(clk_sys), .nrst(nrst),
        .bus_style_sel(bus_if.bus_style_sel), .data_host_oe(bus_if.data_host_oe),
        .data_dev_out(bus_if.data_dev_out), .data_dev_oe(bus_if.data_dev_oe),
        .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .chan_a_select_n(bus_if.chan_a_select_n), .chan_b_select_n(bus_if.chan_b_select_n),
        .chan_a_irq_out(bus_if.chan_a_irq_out), .chan_a_irq_oe(bus_if.chan_a_irq_oe),
        .chan_b_irq_oe(bus_if.chan_b_irq_oe), .chan_a_aux_out_n(bus_if.chan_a_aux_out_n));

    // Clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Latch each store; the pulse lasts one cycle only
    always @(posedge clk_sys) begin
        if (write_pulse === 1'b1) begin
            wr_where <= {write_chan_b, write_addr};
            wr_data_seen <= write_data;
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Bounded wait for ready or response at falling edges
    task automatic wait_for(input bit rsp, input string what);
        int i;
        i = 0;
        while (((rsp ? rsp_valid : req_ready) !== 1'b1) && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        if (i >= 200) begin
            failures++;
            $display("Error at %0t: timeout on %s", $time, what);
            final_report();
        end
    endtask

    // One transfer; idles after so the synchroniser and store settle
    task automatic xfer(input duhbp_cmd_t cmd, input logic chb, input logic [2:0] a,
                        input logic [7:0] wd);
        wait_for(1'b0, "ready");
        req_valid = 1'b1;
        req_cmd = cmd;
        req_chan_b = chb;
        req_addr = a;
        req_wdata = wd;
        @(negedge clk_sys);
        req_valid = 1'b0;
        wait_for(1'b1, "response");
        rd = rsp_rdata;
        repeat (8) @(negedge clk_sys);
    endtask

    // Style strap changes only under reset
    task automatic do_reset(input logic s);
        nrst = 1'b0;
        style_strobe = s;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
    endtask

    // Main sequence
    initial begin
        failures = 0;
        n_checks = 0;
        req_valid = 1'b0;
        req_cmd = DUHBP_CMD_READ;
        req_chan_b = 1'b0;
        req_addr = 3'h0;
        req_wdata = 8'h00;
        chan_a_int_req = 1'b0;
        chan_b_int_req = 1'b0;
        do_reset(1'b1);
        // Strobe style: every register of both channels, bit 3 kept clear
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 8; a++) begin
                xfer(DUHBP_CMD_WRITE, c[0], a[2:0], {c[0] ? 4'h5 : 4'hA, 1'b0, a[2:0]});
                check({4'h0, wr_where}, {4'h0, c[0], a[2:0]}, "store place");
                check(wr_data_seen, {c[0] ? 4'h5 : 4'hA, 1'b0, a[2:0]}, "store byte");
            end
        end
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 8; a++) begin
                xfer(DUHBP_CMD_READ, c[0], a[2:0], 8'h00);
                check(rd, {c[0] ? 4'h5 : 4'hA, 1'b0, a[2:0]}, "read back");
            end
        end
        check(chan_a_mcr, 8'hA4, "modem control a");
        check(chan_b_mcr, 8'h54, "modem control b");
        // Interrupt gating by modem control bit 3
        chan_a_int_req = 1'b1;
        chan_b_int_req = 1'b1;
        xfer(DUHBP_CMD_WRITE, 1'b0, 3'h4, 8'h08);
        check({5'h00, bus_if.chan_a_irq_oe, bus_if.chan_a_irq_out, bus_if.chan_a_aux_out_n},
              8'h06, "irq a on");
        check({7'h00, bus_if.chan_b_irq_oe}, 8'h00, "irq b gated");
        check({7'h00, irq_seen}, 8'h01, "irq seen");
        xfer(DUHBP_CMD_WRITE, 1'b1, 3'h4, 8'h08);
        check({6'h00, bus_if.chan_b_irq_oe, bus_if.chan_b_irq_out}, 8'h03, "irq b on");
        xfer(DUHBP_CMD_WRITE, 1'b0, 3'h4, 8'h00);
        check({6'h00, bus_if.chan_a_irq_oe, bus_if.chan_a_aux_out_n}, 8'h01, "irq a off");
        // Direction style: select B becomes the channel bit
        chan_a_int_req = 1'b0;
        chan_b_int_req = 1'b0;
        do_reset(1'b0);
        xfer(DUHBP_CMD_READ, 1'b1, 3'h3, 8'h00);
        check(rd, 8'h00, "reset value");
        xfer(DUHBP_CMD_WRITE, 1'b1, 3'h3, 8'h3C);
        check({4'h0, wr_where}, 8'h0B, "direction store place");
        xfer(DUHBP_CMD_WRITE, 1'b0, 3'h3, 8'hC3);
        xfer(DUHBP_CMD_READ, 1'b1, 3'h3, 8'h00);
        check(rd, 8'h3C, "channel b read");
        xfer(DUHBP_CMD_READ, 1'b0, 3'h3, 8'h00);
        check(rd, 8'hC3, "channel a read");
        // Shared interrupt only ever pulls low
        xfer(DUHBP_CMD_WRITE, 1'b0, 3'h4, 8'h08);
        chan_a_int_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({6'h00, bus_if.chan_a_irq_oe, bus_if.chan_a_irq_out}, 8'h02, "shared irq");
        check({7'h00, irq_seen}, 8'h01, "shared irq seen");
        check({7'h00, bus_if.chan_b_irq_oe}, 8'h00, "irq b unused");
        chan_a_int_req = 1'b0;
        repeat (4) @(negedge clk_sys);
        check({7'h00, bus_if.chan_a_irq_oe}, 8'h00, "shared irq released");
        check({7'h00, irq_seen}, 8'h00, "shared irq seen clear");
        final_report();
    end
endmodule
